// ==== design/odse_pkg.sv ====
// odse_pkg: register map, field positions and reset values of the
// output driver stage enable control bank.
// assumes: included before any odse module, 32-bit ahb-lite data.

package odse_pkg;

   // ***********************************************************
   // register map
   // ***********************************************************
   localparam logic [7:0] ODSE_PHONE_IDX = 8'h5A; // register index
   localparam logic [7:0] ODSE_LINE_IDX  = 8'h5E;
   localparam int         ODSE_ADDR_W    = 10;    // index times four
   localparam logic [9:0] ODSE_PHONE_ADDR = {ODSE_PHONE_IDX, 2'b00};
   localparam logic [9:0] ODSE_LINE_ADDR  = {ODSE_LINE_IDX, 2'b00};
   localparam logic [7:0] ODSE_CTRL_RST  = 8'h00;

   // ***********************************************************
   // field positions inside each control register
   // ***********************************************************
   localparam int ODSE_L_SHORT_REL = 7;
   localparam int ODSE_L_OUT_ON    = 6;
   localparam int ODSE_L_MID_ON    = 5;
   localparam int ODSE_L_IN_ON     = 4;
   localparam int ODSE_R_SHORT_REL = 3;
   localparam int ODSE_R_OUT_ON    = 2;
   localparam int ODSE_R_MID_ON    = 1;
   localparam int ODSE_R_IN_ON     = 0;

   // ***********************************************************
   // bus encodings
   // ***********************************************************
   localparam logic [1:0]  ODSE_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  ODSE_HTRANS_SEQ    = 2'h3;
   localparam logic [31:0] ODSE_RDATA_RST     = 32'h0000_0000;

   typedef enum logic {ODSE_IDLE, ODSE_DATA} odse_phase_e;

endpackage : odse_pkg

// ==== design/odse_stage_reg.sv ====
// odse_stage_reg: one 8-bit stage control register with byte write.
// assumes: write strobe already decoded and qualified by the bus.

`timescale 1ns/1ps
`default_nettype none

module odse_stage_reg (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] ctrl_q
);
   import odse_pkg::*;

   // ***********************************************************
   // storage
   // ***********************************************************
   // reset clears every bit: shorts applied, stages off
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= ODSE_CTRL_RST;
      end else if (clk_en && wr_en) begin
         ctrl_q <= wr_data;
      end
   end

endmodule : odse_stage_reg

`default_nettype wire

// ==== design/odse_top.sv ====
// odse_top: ahb-lite slave holding the headphone and line output stage
// control registers, driving stage enables and ground shorts per path.
// assumes: single ahb-lite master, one slave, core_clk 50 MHz.

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - after reset all four outputs are shorted to analogue ground.
// - bit 7 releases left short, bit 3 right short; zero reapplies.
// - bit 6 enables left output stage, bit 2 the right one.
// - bit 5 enables left middle stage, bit 1 the right one.
// - bit 4 enables left input stage, bit 0 the right one.
module odse_top (
   input  wire logic                          core_clk,
   input  wire logic                          rst_b,
   input  wire logic                          clk_en,
   input  wire logic                          hsel,
   input  wire logic [odse_pkg::ODSE_ADDR_W-1:0] haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic      [31:0]                   hrdata,
   output logic                               phone_left_short_to_gnd,
   output logic                               phone_right_short_to_gnd,
   output logic                               line_left_short_to_gnd,
   output logic                               line_right_short_to_gnd,
   output logic                               phone_left_input_stage_on,
   output logic                               phone_left_middle_stage_on,
   output logic                               phone_left_output_stage_on,
   output logic                               phone_right_input_stage_on,
   output logic                               phone_right_middle_stage_on,
   output logic                               phone_right_output_stage_on,
   output logic                               line_left_input_stage_on,
   output logic                               line_left_middle_stage_on,
   output logic                               line_left_output_stage_on,
   output logic                               line_right_input_stage_on,
   output logic                               line_right_middle_stage_on,
   output logic                               line_right_output_stage_on
);
   import odse_pkg::*;

   // ***********************************************************
   // address phase capture
   // ***********************************************************
   logic                   wr_pend_r;
   logic                   rd_pend_r;
   logic [ODSE_ADDR_W-1:0] addr_r;
   logic [7:0]             phone_q;
   logic [7:0]             line_q;
   logic [31:0]            hrdata_r;

   wire addr_valid = hsel && hready &&
                     (htrans == ODSE_HTRANS_NONSEQ ||
                      htrans == ODSE_HTRANS_SEQ);
   wire hit_phone_a = (haddr == ODSE_PHONE_ADDR);
   wire hit_line_a  = (haddr == ODSE_LINE_ADDR);

   // zero wait states, so the slave is always ready and always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // latch the address phase; write data arrives one cycle later
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= '0;
      end else if (clk_en) begin
         wr_pend_r <= addr_valid && hwrite;
         rd_pend_r <= addr_valid && !hwrite;
         addr_r    <= haddr;
      end
   end

   // ***********************************************************
   // register writes in the data phase
   // ***********************************************************
   // hsize is ignored: only word transfers are issued, low byte holds data
   wire phone_wr = wr_pend_r && (addr_r == ODSE_PHONE_ADDR);
   wire line_wr  = wr_pend_r && (addr_r == ODSE_LINE_ADDR);

   // one register per output pair; a write to one never touches the other
   odse_stage_reg u_phone_reg (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .wr_en    (phone_wr),
      .wr_data  (hwdata[7:0]),
      .ctrl_q   (phone_q)
   );

   odse_stage_reg u_line_reg (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .wr_en    (line_wr),
      .wr_data  (hwdata[7:0]),
      .ctrl_q   (line_q)
   );

   // ***********************************************************
   // read data
   // ***********************************************************
   // a read address phase can meet the data phase of a write to the
   // same register; forward the bus byte so the read is not stale
   wire [7:0] phone_now = phone_wr ? hwdata[7:0] : phone_q;
   wire [7:0] line_now  = line_wr  ? hwdata[7:0] : line_q;

   // unmapped addresses read zero; upper bits always zero
   wire [7:0] rd_sel = hit_phone_a ? phone_now :
                       hit_line_a  ? line_now  : 8'h00;

   // registered read data, loaded at the address phase edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata_r <= ODSE_RDATA_RST;
      end else if (clk_en && addr_valid && !hwrite) begin
         hrdata_r <= {24'h00_0000, rd_sel};
      end
   end
   assign hrdata = hrdata_r;

   // ***********************************************************
   // stage enables and ground shorts
   // ***********************************************************
   // short is held while release bit is clear, reset included
   assign phone_left_short_to_gnd  = ~phone_q[ODSE_L_SHORT_REL];
   assign phone_right_short_to_gnd = ~phone_q[ODSE_R_SHORT_REL];
   assign line_left_short_to_gnd   = ~line_q[ODSE_L_SHORT_REL];
   assign line_right_short_to_gnd  = ~line_q[ODSE_R_SHORT_REL];

   // output stages
   assign phone_left_output_stage_on  = phone_q[ODSE_L_OUT_ON];
   assign phone_right_output_stage_on = phone_q[ODSE_R_OUT_ON];
   assign line_left_output_stage_on   = line_q[ODSE_L_OUT_ON];
   assign line_right_output_stage_on  = line_q[ODSE_R_OUT_ON];

   // intermediate stages; settle timing is left to software
   assign phone_left_middle_stage_on  = phone_q[ODSE_L_MID_ON];
   assign phone_right_middle_stage_on = phone_q[ODSE_R_MID_ON];
   assign line_left_middle_stage_on   = line_q[ODSE_L_MID_ON];
   assign line_right_middle_stage_on  = line_q[ODSE_R_MID_ON];

   // input stages
   assign phone_left_input_stage_on  = phone_q[ODSE_L_IN_ON];
   assign phone_right_input_stage_on = phone_q[ODSE_R_IN_ON];
   assign line_left_input_stage_on   = line_q[ODSE_L_IN_ON];
   assign line_right_input_stage_on  = line_q[ODSE_R_IN_ON];

   // hsize unused on purpose: word-only master
   wire unused_ok = &{1'b0, hsize};

endmodule : odse_top

`default_nettype wire

// ==== testbench/odse_props.sv ====
// odse_props: concurrent checks on the stage control bank outputs.
// assumes: bound onto odse_top, zero-wait ahb-lite data phase.
`timescale 1ns/1ps
`default_nettype none
module odse_props
   import odse_pkg::*;
(
   input wire logic                               core_clk,
   input wire logic                               rst_b,
   input wire logic                               clk_en,
   input wire logic                               hsel,
   input wire logic [odse_pkg::ODSE_ADDR_W-1:0]   haddr,
   input wire logic [1:0]                         htrans,
   input wire logic                               hwrite,
   input wire logic [31:0]                        hwdata,
   input wire logic                               hready,
   input wire logic                               phone_left_short_to_gnd,
   input wire logic                               phone_right_short_to_gnd,
   input wire logic                               line_left_short_to_gnd,
   input wire logic                               line_right_short_to_gnd,
   input wire logic                               phone_left_output_stage_on,
   input wire logic                               phone_right_output_stage_on,
   input wire logic                               line_left_middle_stage_on,
   input wire logic                               line_right_middle_stage_on,
   input wire logic                               phone_left_input_stage_on,
   input wire logic                               phone_right_input_stage_on
);
   // ************************************************************
   // write cycle: address phase taken, then its data phase
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_wr(logic [9:0] a);
      hsel && hready && htrans[1] && hwrite && clk_en && haddr == a ##1 clk_en;
   endsequence
   // outputs land on the edge that closes the data phase and are checked one edge later
   a_reset_shorts_all: assert property ($rose(rst_b) |-> phone_left_short_to_gnd && phone_right_short_to_gnd && line_left_short_to_gnd && line_right_short_to_gnd) else $error("path not shorted after reset");
   a_phone_short_rel: assert property (s_wr(ODSE_PHONE_ADDR) |=> phone_left_short_to_gnd == !$past(hwdata[7]) && phone_right_short_to_gnd == !$past(hwdata[3])) else $error("phone short wrong");
   a_line_short_rel: assert property (s_wr(ODSE_LINE_ADDR) |=> line_left_short_to_gnd == !$past(hwdata[7]) && line_right_short_to_gnd == !$past(hwdata[3])) else $error("line short wrong");
   a_phone_out_stage: assert property (s_wr(ODSE_PHONE_ADDR) |=> phone_left_output_stage_on == $past(hwdata[6]) && phone_right_output_stage_on == $past(hwdata[2])) else $error("output stage wrong");
   a_line_mid_stage: assert property (s_wr(ODSE_LINE_ADDR) |=> line_left_middle_stage_on == $past(hwdata[5]) && line_right_middle_stage_on == $past(hwdata[1])) else $error("middle stage wrong");
   a_phone_in_stage: assert property (s_wr(ODSE_PHONE_ADDR) |=> phone_left_input_stage_on == $past(hwdata[4]) && phone_right_input_stage_on == $past(hwdata[0])) else $error("input stage wrong");
   a_paths_apart: assert property (s_wr(ODSE_PHONE_ADDR) |=> $stable(line_left_short_to_gnd) && $stable(line_right_middle_stage_on)) else $error("line path moved");
endmodule : odse_props
bind odse_top odse_props u_props (.core_clk, .rst_b, .clk_en, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .phone_left_short_to_gnd,
   .phone_right_short_to_gnd, .line_left_short_to_gnd, .line_right_short_to_gnd,
   .phone_left_output_stage_on, .phone_right_output_stage_on,
   .line_left_middle_stage_on, .line_right_middle_stage_on,
   .phone_left_input_stage_on, .phone_right_input_stage_on);
`default_nettype wire

// ==== testbench/tb.sv ====
// tb: self-checking bench for the stage control bank over ahb-lite.
// assumes: zero-wait slave, 50 MHz core_clk, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import odse_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_b    = 1'b0;
   logic        clk_en   = 1'b1;
   logic        hsel     = 1'b0;
   logic        hwrite   = 1'b0;
   logic [9:0]  haddr    = 10'h000;
   logic [1:0]  htrans   = 2'h0;
   logic [31:0] hwdata   = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   wire logic   hready;
   wire logic [15:0] pv;   // pins laid out like {phone, line} register bits
   int          mismatches = 0;
   int          checks_done = 0;
   assign hready = hreadyout;
   always #10 core_clk = ~core_clk;
   odse_top uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
      .phone_left_short_to_gnd(pv[15]), .phone_left_output_stage_on(pv[14]),
      .phone_left_middle_stage_on(pv[13]), .phone_left_input_stage_on(pv[12]),
      .phone_right_short_to_gnd(pv[11]), .phone_right_output_stage_on(pv[10]),
      .phone_right_middle_stage_on(pv[9]), .phone_right_input_stage_on(pv[8]),
      .line_left_short_to_gnd(pv[7]), .line_left_output_stage_on(pv[6]),
      .line_left_middle_stage_on(pv[5]), .line_left_input_stage_on(pv[4]),
      .line_right_short_to_gnd(pv[3]), .line_right_output_stage_on(pv[2]),
      .line_right_middle_stage_on(pv[1]), .line_right_input_stage_on(pv[0]));
   // ************************************************************
   // bus and compare tasks
   // ************************************************************
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   // bounded wait on hready; a stuck bus ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         mismatches++;
         stop_test();
      end
   endtask : wait_rdy
   task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= ODSE_HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] rd;
      xfer(a, 1'b1, d, rd);
   endtask : wr
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
      logic [31:0] rd;
      xfer(a, 1'b0, 32'h0, rd);
      chk({24'h0, e}, rd);
   endtask : rd_chk
   // settle past the edge, then realign so drives stay on the edge
   task automatic pins(input logic [7:0] p, input logic [7:0] l);
      #1 chk({16'h0, p, l} ^ 32'h8888, {16'h0, pv});
      @(posedge core_clk);
   endtask : pins
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_fields();
      logic [7:0] v;
      pins(8'h00, 8'h00);
      for (int r = 0; r < 2; r++)
         for (int i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            wr(r ? ODSE_LINE_ADDR : ODSE_PHONE_ADDR, {24'hFFFFFF, v});
            pins(r ? 8'h80 : v, r ? v : 8'h00);
            rd_chk(r ? ODSE_LINE_ADDR : ODSE_PHONE_ADDR, v);
         end
      $display("field test done");
   endtask : t_fields
   task automatic t_sequence();
      logic [7:0] st [6] = '{8'h11, 8'h33, 8'h77, 8'hFF, 8'h77, 8'h00};
      for (int i = 0; i < 6; i++) begin
         wr(ODSE_LINE_ADDR, {24'h0, st[i]});
         pins(8'h80, st[i]);
         repeat (i == 0 ? 1000 : 4) @(posedge core_clk);
      end
      wr(10'h000, 32'hFF);
      wr(ODSE_PHONE_ADDR + 10'h4, 32'hFF);
      pins(8'h80, 8'h00);
      rd_chk(10'h16C, 8'h00);
      $display("sequence test done");
   endtask : t_sequence
   task automatic t_reset_mid();
      wr(ODSE_PHONE_ADDR, 32'hFF);
      rst_b <= 1'b0;
      pins(8'h00, 8'h00);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rd_chk(ODSE_PHONE_ADDR, 8'h00);
      $display("reset test done");
   endtask : t_reset_mid
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_fields();
      t_sequence();
      t_reset_mid();
      stop_test();
   end
endmodule : tb
`default_nettype wire
